// *** hw/config_word_defines.svh ***
/*
 Offsets, field positions, reset values and timing counts for the
 configuration word decoder. Assumes a 50 MHz system clock.
*/
`ifndef CONFIG_WORD_DEFINES_SVH
`define CONFIG_WORD_DEFINES_SVH

// Programming address space
`define CFG_WORD_ADDR      14'h2007
`define CFG_SPACE_LO       14'h2000
`define CFG_SPACE_HI       14'h3FFF

// Field positions inside the configuration word
`define CFG_OSC_LSB        0
`define CFG_OSC_MSB        2
`define CFG_WDT_BIT        3
`define CFG_POWERUP_DELAY_TIMER_N_BIT     4
`define CFG_RSTPIN_BIT     5
`define CFG_LOCK_BIT       6
`define CFG_FREQ_BIT       7
`define CFG_BOR_LSB        8
`define CFG_BOR_MSB        9
`define CFG_IMPL_BITS      10

// Erased word, and the pattern unimplemented bits read back as
`define CFG_ERASED         10'h3FF
`define CFG_UNIMPL_ONES    6'h3F
`define CFG_NO_DATA        16'hFFFF

// Timing
`define CLK_FREQ_HZ        50000000
`define POWERUP_DELAY_TIMER_TIME_MS       64
`define POWERUP_DELAY_TIMER_CYCLES        (`POWERUP_DELAY_TIMER_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define OST_CYCLES         1024

`endif

// *** hw/config_word_pkg.sv ***
/*
 Types shared by the configuration word decoder.
 Assumes config_word_defines.svh supplies the numeric constants.
*/
package config_word_pkg;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_POWERUP_DELAY_TIMER = 2'b01,
      ST_OST  = 2'b11,
      ST_RUN  = 2'b10
   } seq_state_t;

   typedef enum logic [2:0] {
      OSC_LOW_POWER_CRYSTAL  = 3'h0,
      OSC_MEDIUM_CRYSTAL     = 3'h1,
      OSC_HIGH_SPEED_CRYSTAL = 3'h2,
      OSC_EXTERNAL_CLOCK     = 3'h3,
      OSC_INTERNAL_IO        = 3'h4,
      OSC_INTERNAL_CLOCK_OUTPUT_PIN    = 3'h5,
      OSC_RC_IO              = 3'h6,
      OSC_RC_CLOCK_OUTPUT_PIN          = 3'h7
   } osc_mode_t;

   typedef enum logic [1:0] {
      BOR_OFF_A   = 2'b00,
      BOR_OFF_B   = 2'b01,
      BOR_AWAKE   = 2'b10,
      BOR_ALWAYS  = 2'b11
   } brownout_mode_t;

endpackage

// *** hw/delay_timer.sv ***
/*
 Down-counter used for the power-up and oscillator start-up delays.
 Assumes a synchronous load pulse; expired_o rises exactly load_val_i
 clock edges after the load edge and stays high until the next load.
*/
`timescale 1ns/1ns
`default_nettype none

module delay_timer #(
   parameter int WIDTH = 22
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Control
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] load_val_i,
   // Status
   output logic                  expired_o
);

   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   logic             expired_nxt;

   if (WIDTH < 2)
   begin : g_chk
      $error("delay_timer WIDTH must be at least 2");
   end

   always_comb
   begin
      count_nxt   = count_r;
      expired_nxt = expired_o;
      if (load_i)
      begin
         count_nxt   = load_val_i;
         expired_nxt = 1'b0;
      end
      else if (count_r != '0)
      begin
         count_nxt   = count_r - WIDTH'(1);
         expired_nxt = (count_r == WIDTH'(1));
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count_r   <= '0;
         expired_o <= 1'b0;
      end
      else
      begin
         count_r   <= count_nxt;
         expired_o <= expired_nxt;
      end
   end

endmodule // delay_timer

`default_nettype wire

// *** hw/config_word_decode.sv ***
/*
 Configuration word store and decoder with the reset, start-up timer
 and sleep sequencing that its fields steer.
 Assumes all inputs synchronous to clk_i; rst_b_i is the logic's own
 power rail reset, por_i marks a device power-on event.
*/
// What this block does
// - Programmed bit reads 0, erased reads 1
// - Word at 2007h, programmer-only access
// - Brown-out mode 10: off in Sleep
// - Bit 5 makes pin the external reset
// - Bit 3 enables the watchdog
// - External reset stops internal/RC oscillator
// - Power-up timer holds reset 64 ms
// - Brown-out resets and reruns power-up timer
// - Start-up timer waits for crystal
// - Wake on reset, watchdog or interrupt
// - Power-up timer enable bit is inverted
`timescale 1ns/1ns
`default_nettype none
`include "config_word_defines.svh"

module config_word_decode
   import config_word_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYCLES,
   parameter int OST_CYCLES  = `OST_CYCLES,
   parameter int TMR_W       = 22
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Programming path
   input  wire logic        prog_mode_i,
   input  wire logic [13:0] prog_addr_i,
   input  wire logic        prog_wr_i,
   input  wire logic [15:0] prog_wdata_i,
   input  wire logic        prog_rd_i,
   output logic      [15:0] prog_rdata_o,
   // Reset and wake sources
   input  wire logic        por_i,
   input  wire logic        brownout_detect_i,
   input  wire logic        ext_reset_n_i,
   input  wire logic        wdt_reset_i,
   input  wire logic        wdt_wakeup_i,
   input  wire logic        irq_i,
   input  wire logic        sleep_req_i,
   // Decoded settings
   output logic [1:0]       brownout_mode_select_o,
   output logic             brownout_active_o,
   output logic             internal_osc_freq_select_o,
   output logic             program_memory_lock_o,
   output logic             reset_pin_function_select_o,
   output logic             powerup_delay_enabled_o,
   output logic             watchdog_enable_o,
   output logic [2:0]       osc_mode_o,
   output logic             clock_output_pin_is_io_o,
   // Sequencing
   output logic             device_reset_o,
   output logic             osc_run_o,
   output logic             sleeping_o,
   output logic             wake_o
);

   if (POWERUP_DELAY_TIMER_CYCLES < 1 || OST_CYCLES < 1 ||
       POWERUP_DELAY_TIMER_CYCLES >= (2 ** TMR_W) || OST_CYCLES >= (2 ** TMR_W))
   begin : g_chk
      $error("config_word_decode timer counts do not fit TMR_W");
   end

   // Reset release through two flops
   logic rst_s1_r;
   logic rst_n;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   function automatic logic is_crystal(input logic [2:0] m);
      return (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_MEDIUM_CRYSTAL) ||
             (m == OSC_HIGH_SPEED_CRYSTAL);
   endfunction

   function automatic logic is_on_chip_osc(input logic [2:0] m);
      return m[2];
   endfunction

   function automatic logic bor_enabled(input logic [1:0] b,
                                        input logic       asleep);
      return (b == BOR_ALWAYS) || ((b == BOR_AWAKE) && !asleep);
   endfunction

   // Non-volatile store, only the implemented bits are kept
   logic [`CFG_IMPL_BITS-1:0] store_r;
   logic [`CFG_IMPL_BITS-1:0] store_nxt;
   logic [15:0]               rdata_nxt;
   logic                      hit;

   assign hit = prog_mode_i && (prog_addr_i == `CFG_WORD_ADDR);

   always_comb
   begin
      store_nxt = store_r;
      rdata_nxt = prog_rdata_o;
      if (prog_wr_i && hit)
         store_nxt = prog_wdata_i[`CFG_IMPL_BITS-1:0];
      if (prog_rd_i)
      begin
         if (hit)
            rdata_nxt = {`CFG_UNIMPL_ONES, store_r};
         else
            rdata_nxt = `CFG_NO_DATA;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         store_r      <= `CFG_ERASED;
         prog_rdata_o <= `CFG_NO_DATA;
      end
      else
      begin
         store_r      <= store_nxt;
         prog_rdata_o <= rdata_nxt;
      end
   end

   // Sequencer
   seq_state_t                st_r;
   seq_state_t                st_nxt;
   logic [`CFG_IMPL_BITS-1:0] cfg_r;
   logic [`CFG_IMPL_BITS-1:0] cfg_nxt;
   logic                      powerup_delay_timer_pend_r;
   logic                      powerup_delay_timer_pend_nxt;
   logic                      sleep_nxt;
   logic                      wake_nxt;
   logic                      tmr_load;
   logic [TMR_W-1:0]          tmr_val;
   logic                      tmr_done;
   logic                      ext_rst;
   logic                      bor_hit;
   logic                      reset_event;
   logic [2:0]                osc_nxt;

   // Pin acts as reset only when so configured
   assign ext_rst     = cfg_r[`CFG_RSTPIN_BIT] && !ext_reset_n_i;
   assign bor_hit     = brownout_active_o && brownout_detect_i;
   assign reset_event = por_i || bor_hit || wdt_reset_i || ext_rst;
   assign osc_nxt     = store_r[`CFG_OSC_MSB:`CFG_OSC_LSB];

   always_comb
   begin
      st_nxt        = st_r;
      cfg_nxt       = cfg_r;
      powerup_delay_timer_pend_nxt = powerup_delay_timer_pend_r || por_i || bor_hit;
      sleep_nxt     = sleeping_o;
      wake_nxt      = 1'b0;
      tmr_load      = 1'b0;
      tmr_val       = TMR_W'(OST_CYCLES);
      case (st_r)
         ST_HOLD:
         begin
            cfg_nxt   = store_r;
            sleep_nxt = 1'b0;
            if (!reset_event)
            begin
               // Cleared bit enables the delay
               if (powerup_delay_timer_pend_r && !store_r[`CFG_POWERUP_DELAY_TIMER_N_BIT])
               begin
                  st_nxt   = ST_POWERUP_DELAY_TIMER;
                  tmr_load = 1'b1;
                  tmr_val  = TMR_W'(POWERUP_DELAY_TIMER_CYCLES);
               end
               else if (is_crystal(osc_nxt))
               begin
                  st_nxt   = ST_OST;
                  tmr_load = 1'b1;
               end
               else
                  st_nxt = ST_RUN;
               powerup_delay_timer_pend_nxt = 1'b0;
            end
         end
         ST_POWERUP_DELAY_TIMER:
         begin
            if (reset_event)
               st_nxt = ST_HOLD;
            else if (tmr_done && is_crystal(cfg_r[2:0]))
            begin
               st_nxt   = ST_OST;
               tmr_load = 1'b1;
            end
            else if (tmr_done)
               st_nxt = ST_RUN;
         end
         ST_OST:
         begin
            if (reset_event)
               st_nxt = ST_HOLD;
            else if (tmr_done)
               st_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            if (reset_event)
               st_nxt = ST_HOLD;
            else if (sleeping_o && (wdt_wakeup_i || irq_i))
            begin
               sleep_nxt = 1'b0;
               wake_nxt  = 1'b1;
            end
            else if (sleep_req_i)
               sleep_nxt = 1'b1;
         end
         default:
            st_nxt = ST_HOLD;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r        <= ST_HOLD;
         cfg_r       <= `CFG_ERASED;
         powerup_delay_timer_pend_r <= 1'b1;
         sleeping_o  <= 1'b0;
         wake_o      <= 1'b0;
      end
      else
      begin
         st_r        <= st_nxt;
         cfg_r       <= cfg_nxt;
         powerup_delay_timer_pend_r <= powerup_delay_timer_pend_nxt;
         sleeping_o  <= sleep_nxt;
         wake_o      <= wake_nxt;
      end
   end

   delay_timer #(
      .WIDTH      (TMR_W)
   ) u_timer (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .load_i     (tmr_load),
      .load_val_i (tmr_val),
      .expired_o  (tmr_done)
   );

   // Registered decoded outputs
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         brownout_mode_select_o      <= BOR_ALWAYS;
         brownout_active_o           <= 1'b1;
         internal_osc_freq_select_o  <= 1'b1;
         program_memory_lock_o       <= 1'b0;
         reset_pin_function_select_o <= 1'b1;
         powerup_delay_enabled_o     <= 1'b0;
         watchdog_enable_o           <= 1'b1;
         osc_mode_o                  <= OSC_RC_CLOCK_OUTPUT_PIN;
         clock_output_pin_is_io_o    <= 1'b0;
         device_reset_o              <= 1'b1;
         osc_run_o                   <= 1'b0;
      end
      else
      begin
         brownout_mode_select_o <= cfg_nxt[`CFG_BOR_MSB:`CFG_BOR_LSB];
         brownout_active_o      <= bor_enabled(
            cfg_nxt[`CFG_BOR_MSB:`CFG_BOR_LSB], sleep_nxt);
         internal_osc_freq_select_o  <= cfg_nxt[`CFG_FREQ_BIT];
         program_memory_lock_o       <= !cfg_nxt[`CFG_LOCK_BIT];
         reset_pin_function_select_o <= cfg_nxt[`CFG_RSTPIN_BIT];
         powerup_delay_enabled_o     <= !cfg_nxt[`CFG_POWERUP_DELAY_TIMER_N_BIT];
         watchdog_enable_o           <= cfg_nxt[`CFG_WDT_BIT];
         osc_mode_o <= cfg_nxt[`CFG_OSC_MSB:`CFG_OSC_LSB];
         clock_output_pin_is_io_o    <=
            (cfg_nxt[2:0] == OSC_INTERNAL_IO) || (cfg_nxt[2:0] == OSC_RC_IO);
         device_reset_o <= (st_nxt != ST_RUN);
         // Pin reset stops the on-chip oscillator to save power
         osc_run_o <= !(cfg_r[`CFG_RSTPIN_BIT] && !ext_reset_n_i &&
                        is_on_chip_osc(cfg_r[2:0]));
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence seq_pin_reset_onchip;
      cfg_r[`CFG_RSTPIN_BIT] && !ext_reset_n_i && cfg_r[2];
   endsequence

   sequence seq_hold_exit_powerup_delay_timer;
      st_r == ST_HOLD && !reset_event && powerup_delay_timer_pend_r;
   endsequence

   AST_UNIMPL_ONES: assert property (
      prog_rd_i |=> prog_rdata_o[15:10] == `CFG_UNIMPL_ONES)
      else $error("unimplemented bits did not read as one");

   AST_PROG_ONLY: assert property (
      (prog_wr_i && !prog_mode_i) |=> $stable(store_r))
      else $error("store changed outside programming mode");

   AST_BOR_SLEEP: assert property (
      (brownout_mode_select_o == BOR_AWAKE && sleeping_o)
      |-> !brownout_active_o)
      else $error("brown-out active in sleep for mode 10");

   AST_OSC_STOP: assert property (
      seq_pin_reset_onchip |=> !osc_run_o)
      else $error("on-chip oscillator ran during pin reset");

   AST_POWERUP_DELAY_TIMER_ENTRY: assert property (
      seq_hold_exit_powerup_delay_timer |=> (st_r == ST_POWERUP_DELAY_TIMER) == !cfg_r[`CFG_POWERUP_DELAY_TIMER_N_BIT])
      else $error("power-up timer enable polarity wrong");

   AST_POWERUP_DELAY_TIMER_HOLD: assert property (
      (st_r == ST_POWERUP_DELAY_TIMER && !tmr_done) |-> device_reset_o)
      else $error("reset released during power-up delay");

   AST_BOR_RESET: assert property (
      bor_hit |=> st_r == ST_HOLD && powerup_delay_timer_pend_r && device_reset_o)
      else $error("brown-out did not reset the sequence");

   AST_OST_CRYSTAL: assert property (
      (st_r == ST_POWERUP_DELAY_TIMER && tmr_done && !reset_event && is_crystal(cfg_r[2:0]))
      |=> st_r == ST_OST ##1 device_reset_o)
      else $error("crystal mode skipped start-up timer");

   AST_WAKE: assert property (
      (st_r == ST_RUN && sleeping_o && irq_i && !reset_event)
      |=> !sleeping_o && wake_o ##1 !wake_o)
      else $error("interrupt did not wake from sleep");

   AST_CFG_STABLE: assert property (
      (st_r == ST_RUN) [*2] |-> $stable(cfg_r))
      else $error("configuration changed while running");

   AST_WDT_FIELD: assert property (
      st_r == ST_RUN |-> watchdog_enable_o == cfg_r[`CFG_WDT_BIT])
      else $error("watchdog enable does not follow its bit");

   AST_FREQ_FIELD: assert property (
      st_r == ST_RUN |-> internal_osc_freq_select_o == cfg_r[`CFG_FREQ_BIT])
      else $error("frequency select does not follow its bit");

endmodule // config_word_decode

`default_nettype wire

// *** test/cfg_programmer_model.sv ***
/*
 External programmer model for the configuration word decoder.
 Assumes callers enter its tasks 2 ns after a rising edge of clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module cfg_programmer_model (
   // Clock
   input  wire logic        clk_i,
   // Programming path
   output var  logic        prog_mode_o,
   output var  logic [13:0] prog_addr_o,
   output var  logic        prog_wr_o,
   output var  logic [15:0] prog_wdata_o,
   output var  logic        prog_rd_o,
   input  wire logic [15:0] prog_rdata_i
);

   initial
   begin
      prog_mode_o  = 1'b0;
      prog_addr_o  = 14'h0000;
      prog_wr_o    = 1'b0;
      prog_wdata_o = 16'h0000;
      prog_rd_o    = 1'b0;
   end

   // Address and data show the inverse once released, never stale values
   task automatic write_word(input logic m, input logic [13:0] a,
                             input logic [15:0] d);
      prog_mode_o  = m;
      prog_addr_o  = a;
      prog_wdata_o = d;
      prog_wr_o    = 1'b1;
      @(posedge clk_i);
      #2;
      prog_wr_o    = 1'b0;
      prog_addr_o  = ~a;
      prog_wdata_o = ~d;
      // Idle cycle so a following call never re-raises a strobe at once
      @(posedge clk_i);
      #2;
   endtask

   task automatic read_word(input logic [13:0] a, output logic [15:0] d);
      prog_mode_o = 1'b1;
      prog_addr_o = a;
      prog_rd_o   = 1'b1;
      @(posedge clk_i);
      #2;
      prog_rd_o   = 1'b0;
      prog_addr_o = ~a;
      @(posedge clk_i);
      #2;
      d = prog_rdata_i;
   endtask

endmodule // cfg_programmer_model

`default_nettype wire

// *** test/config_word_decode_tb.sv ***
/*
 Self-checking bench for the configuration word decoder.
 Assumes shortened power-up and start-up counts set at the instance.
*/
`timescale 1ns/1ns
`default_nettype none

module config_word_decode_tb;
   import config_word_pkg::*;

   localparam int P = 40;
   localparam int O = 8;
   localparam logic [13:0] A = 14'h2007;

   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic pm, wr, rd;
   logic [13:0] pa;
   logic [15:0] wd, rdata;
   logic por = 1'b0, bod = 1'b0, ext_n = 1'b1, wdr = 1'b0;
   logic wdw = 1'b0, irq = 1'b0, slp = 1'b0;
   logic [1:0] bmode;
   logic [2:0] omode;
   logic bact, freq, lock, pinf, pwen, wden, isio, dres, orun, sl, wk;
   int num_errors = 0, tests_run = 0, cycles = 0, wakes = 0;
   logic [15:0] d;
   int n;

   always #10 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (wk === 1'b1)
         wakes <= wakes + 1;
      if (cycles == 4000)
      begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end

   cfg_programmer_model u_cfg_programmer_model (
      .clk_i(clk_i), .prog_mode_o(pm), .prog_addr_o(pa), .prog_wr_o(wr),
      .prog_wdata_o(wd), .prog_rd_o(rd), .prog_rdata_i(rdata));

   config_word_decode #(.POWERUP_DELAY_TIMER_CYCLES(P), .OST_CYCLES(O), .TMR_W(22))
   u_config_word_decode (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .prog_mode_i(pm),
      .prog_addr_i(pa), .prog_wr_i(wr), .prog_wdata_i(wd),
      .prog_rd_i(rd), .prog_rdata_o(rdata), .por_i(por),
      .brownout_detect_i(bod), .ext_reset_n_i(ext_n),
      .wdt_reset_i(wdr), .wdt_wakeup_i(wdw), .irq_i(irq),
      .sleep_req_i(slp), .brownout_mode_select_o(bmode),
      .brownout_active_o(bact), .internal_osc_freq_select_o(freq),
      .program_memory_lock_o(lock),
      .reset_pin_function_select_o(pinf),
      .powerup_delay_enabled_o(pwen), .watchdog_enable_o(wden),
      .osc_mode_o(omode), .clock_output_pin_is_io_o(isio),
      .device_reset_o(dres), .osc_run_o(orun), .sleeping_o(sl),
      .wake_o(wk));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #2;
   endtask

   task automatic pulse(ref logic s);
      s = ~s;
      cyc(1);
      s = ~s;
   endtask

   // Cycles the device stays in reset after the current point
   task automatic measure(output int k);
      k = 0;
      while (dres !== 1'b0 && k < 500)
      begin
         cyc(1);
         k = k + 1;
      end
   endtask

   // Fields packed low to high: osc, wdt, powerup_delay_timer, pin, lock, freq, bor, io
   function automatic logic [15:0] fields();
      return {5'h00, isio, bmode, freq, lock, pinf, pwen, wden, omode};
   endfunction

   task automatic load_word(input logic [15:0] w);
      u_cfg_programmer_model.write_word(1'b1, A, w);
      pulse(por);
      measure(n);
   endtask

   task automatic t_reset_values();
      u_cfg_programmer_model.read_word(A, d);
      check(d, 16'hFFFF);
      check(fields(), 16'h03AF);
      check({15'h0000, dres}, 16'h0000);
   endtask

   task automatic t_prog_path();
      u_cfg_programmer_model.write_word(1'b0, A, 16'h0000);
      u_cfg_programmer_model.write_word(1'b1, 14'h2008, 16'h0000);
      u_cfg_programmer_model.read_word(A, d);
      check(d, 16'hFFFF);
      u_cfg_programmer_model.read_word(14'h2008, d);
      check(d, 16'hFFFF);
      u_cfg_programmer_model.write_word(1'b1, A, 16'h0000);
      u_cfg_programmer_model.read_word(A, d);
      check(d, 16'hFC00);
   endtask

   task automatic t_decode_crystal();
      load_word(16'hFE22);
      check(n >= P + O && n <= P + O + 4, 16'h0001);
      check(n >= P + O && n <= P + O + 4, 16'h0001);
      check(fields(), 16'h0272);
      check(fields(), 16'h0272);
      check(fields(), 16'h0272);
      check({15'h0000, bact}, 16'h0001);
      pulse(bod);
      measure(n);
      check(n >= P + O, 16'h0001);
      // Watchdog reset skips the power-up delay, start-up timer only
      pulse(wdr);
      measure(n);
      check(n >= O && n <= O + 3, 16'h0001);
      u_cfg_programmer_model.write_word(1'b1, A, 16'h03FC);
      cyc(2);
      check(fields(), 16'h0272);
   endtask

   task automatic t_sleep();
      pulse(slp);
      cyc(2);
      check({14'h0000, sl, bact}, 16'h0002);
      n = wakes;
      pulse(irq);
      cyc(2);
      check({15'h0000, sl}, 16'h0000);
      check(16'(wakes - n), 16'h0001);
      pulse(slp);
      pulse(wdw);
      cyc(2);
      check(16'(wakes - n), 16'h0002);
      pulse(slp);
      cyc(2);
      pulse(ext_n);
      cyc(2);
      check({14'h0000, sl, dres}, 16'h0000);
   endtask

   task automatic t_pin_reset();
      load_word(16'h03FC);
      check(n <= 3, 16'h0001);
      check(fields(), 16'h07AC);
      check(fields(), 16'h07AC);
      ext_n = 1'b0;
      cyc(3);
      check({14'h0000, orun, dres}, 16'h0001);
      check({14'h0000, orun, dres}, 16'h0001);
      ext_n = 1'b1;
      cyc(3);
      check({14'h0000, orun, dres}, 16'h0002);
      pulse(wdr);
      cyc(1);
      measure(n);
      check(n <= 3, 16'h0001);
   endtask

   task automatic t_pin_free();
      load_word(16'h03D8);
      check(fields(), 16'h0388);
      ext_n = 1'b0;
      cyc(4);
      check({14'h0000, orun, dres}, 16'h0002);
      ext_n = 1'b1;
   endtask

   task automatic tally_and_finish();
      $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      cyc(6);
      rst_b_i = 1'b1;
      cyc(3);
      t_reset_values();
      t_prog_path();
      t_decode_crystal();
      t_sleep();
      t_pin_reset();
      t_pin_free();
      tally_and_finish();
   end

endmodule // config_word_decode_tb

`default_nettype wire
